// [verilog/serial_port_ctrl.sv]
// Control and status registers of the serial port, with interrupt requests.
// Assumes external shift engines and a synchronous 8-bit register port.
//
// Notes on behaviour
// [R1] Clock select picks sys, sub, /16, /64
// [R2] Subclock halved in active, whole in subactive
// [R3] Control register clears on reset and standby
// [R4] Transmit irq enable gates transmit-empty request
// [R5] Transmit request drops with flag or enable
// [R6] Receive irq enable gates receive and error
// [R7] Receive requests drop with flags or enable
// [R8] Transmit disabled holds buffer-empty flag at one
// [R9] Data write while enabled clears empty flag
// [R10] Software fixes transmit format before enabling
// [R11] Receive enable lets the receiver start
// [R12] Software fixes receive format before enabling
// [R13] Clearing receive enable keeps receive flags
// [R14] Empty flag sets when data moves to shifter
// [R15] Full flag sets on load, clears on read
// [R16] Requests are flag AND enable, every cycle
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module serial_port_ctrl
    import sport_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    input  wire logic              i_standby,
    input  wire logic              i_sub_tick,
    input  wire logic              i_sub_mode,
    input  wire logic              i_tsr_idle,
    input  wire logic              i_rx_done,
    input  wire rx_word_s          i_rx_word,
    output logic      [DATA_W-1:0] o_rdata,
    output logic      [DATA_W-1:0] o_mode,
    output logic      [DATA_W-1:0] o_bit_rate,
    output logic                   o_tx_enable,
    output logic                   o_rx_enable,
    output logic                   o_tx_load,
    output logic      [DATA_W-1:0] o_tx_data,
    output logic                   o_baud_tick,
    output logic                   o_tx_empty_irq,
    output logic                   o_rx_full_irq,
    output logic                   o_rx_error_irq,
    output logic                   o_irq
);

    logic [DATA_W-1:0] mode_q;
    logic [DATA_W-1:0] bitrate_q;
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] txd_q;
    logic [DATA_W-1:0] rxd_q;
    flags_s            flags_q;
    flags_s            flags_d;
    flags_s            seen_q;
    logic              tx_load_d;
    logic              rx_ok;
    logic              rx_ev;
    logic              tx_req_d;
    logic              rx_req_d;
    logic              err_req_d;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   irq_stat;
    logic [EV_W-1:0]   irq_mask;
    logic [DATA_W-1:0] status_rd;
    logic [DATA_W-1:0] rdata_d;
    logic              wr_mode;
    logic              wr_ctrl;
    logic              wr_txd;
    logic              wr_sts;
    logic              rd_sts;
    logic              rd_rxd;
    logic              clr_all;

    assign wr_mode = i_wr_stb && (i_addr == OFS_MODE);
    assign wr_ctrl = i_wr_stb && (i_addr == OFS_CONTROL);
    assign wr_txd  = i_wr_stb && (i_addr == OFS_TXDATA);
    assign wr_sts  = i_wr_stb && (i_addr == OFS_STATUS);
    assign rd_sts  = i_rd_stb && (i_addr == OFS_STATUS);
    assign rd_rxd  = i_rd_stb && (i_addr == OFS_RXDATA);
    assign clr_all = i_rst || i_standby;

    // Mode and bit-rate registers
    always_ff @(posedge i_clk) begin
        if (clr_all) begin
            mode_q <= MODE_RESET;
        end else if (wr_mode) begin
            mode_q <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (clr_all) begin
            bitrate_q <= BITRATE_RESET;
        end else if (i_wr_stb && (i_addr == OFS_BITRATE)) begin
            bitrate_q <= i_wdata;
        end
    end

    // Control register
    always_ff @(posedge i_clk) begin
        if (clr_all) begin
            ctrl_q <= CONTROL_RESET; // [R3]
        end else if (wr_ctrl) begin
            ctrl_q <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            txd_q <= DATA_RESET;
        end else if (wr_txd) begin
            txd_q <= i_wdata;
        end
    end

    // Hand the pending byte to the shifter once it is idle
    assign tx_load_d = ctrl_q[CTL_TX_EN] && !flags_q.tx_buffer_empty && i_tsr_idle && !o_tx_load;

    always_ff @(posedge i_clk) begin
        if (clr_all) begin
            o_tx_load <= 1'b0;
            o_tx_data <= DATA_RESET;
        end else begin
            o_tx_load <= tx_load_d;
            if (tx_load_d) begin
                o_tx_data <= txd_q;
            end
        end
    end

    // Receive completion only counts while reception is enabled
    assign rx_ev = i_rx_done && ctrl_q[CTL_RX_EN]; // [R11]
    assign rx_ok = rx_ev && !i_rx_word.framing_err && !i_rx_word.parity_err
                   && !flags_q.rx_buffer_full;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rxd_q <= DATA_RESET;
        end else if (rx_ok) begin
            rxd_q <= i_rx_word.data; // [R15]
        end
    end

    // Flags: hardware set wins over any clear in the same cycle
    always_comb begin
        flags_d = flags_q;
        if (wr_sts && seen_q.tx_buffer_empty && !i_wdata[STS_TX_BUFFER_EMPTY]) begin
            flags_d.tx_buffer_empty = 1'b0;
        end
        if (wr_txd && ctrl_q[CTL_TX_EN]) begin
            flags_d.tx_buffer_empty = 1'b0; // [R9]
        end
        if (!ctrl_q[CTL_TX_EN] || tx_load_d) begin
            flags_d.tx_buffer_empty = 1'b1; // [R8] [R14]
        end
        if ((wr_sts && seen_q.rx_buffer_full && !i_wdata[STS_RX_BUFFER_FULL]) || rd_rxd) begin
            flags_d.rx_buffer_full = 1'b0; // [R15]
        end
        if (wr_sts && seen_q.overrun_error_flag && !i_wdata[STS_OER]) begin
            flags_d.overrun_error_flag = 1'b0;
        end
        if (wr_sts && seen_q.framing_error_flag && !i_wdata[STS_FER]) begin
            flags_d.framing_error_flag = 1'b0;
        end
        if (wr_sts && seen_q.parity_error_flag && !i_wdata[STS_PER]) begin
            flags_d.parity_error_flag = 1'b0;
        end
        if (rx_ok) begin
            flags_d.rx_buffer_full = 1'b1; // [R15]
        end
        if (rx_ev && flags_q.rx_buffer_full) begin
            flags_d.overrun_error_flag = 1'b1;
        end
        if (rx_ev && i_rx_word.framing_err) begin
            flags_d.framing_error_flag = 1'b1;
        end
        if (rx_ev && i_rx_word.parity_err) begin
            flags_d.parity_error_flag = 1'b1;
        end
    end

    // Receive enable only gates the setting of the receive flags
    always_ff @(posedge i_clk) begin
        if (clr_all) begin
            flags_q <= '{tx_buffer_empty: 1'b1, default: 1'b0};
        end else begin
            flags_q <= flags_d; // [R13]
        end
    end

    // A flag may be cleared by a status write only after it was read as one
    always_ff @(posedge i_clk) begin
        if (clr_all) begin
            seen_q <= '0;
        end else if (rd_sts) begin
            seen_q <= flags_q;
        end else if (wr_sts) begin
            seen_q <= '0;
        end
    end

    // Interrupt request levels
    assign tx_req_d  = ctrl_q[CTL_TX_IRQ_EN] && flags_q.tx_buffer_empty; // [R4] [R5]
    assign rx_req_d  = ctrl_q[CTL_RX_IRQ_EN] && flags_q.rx_buffer_full;  // [R6] [R7]
    assign err_req_d = ctrl_q[CTL_RX_IRQ_EN] && (flags_q.overrun_error_flag
                       || flags_q.framing_error_flag || flags_q.parity_error_flag); // [R6] [R7]

    always_ff @(posedge i_clk) begin
        if (clr_all) begin
            o_tx_empty_irq <= 1'b0;
            o_rx_full_irq  <= 1'b0;
            o_rx_error_irq <= 1'b0;
        end else begin
            o_tx_empty_irq <= tx_req_d;  // [R16]
            o_rx_full_irq  <= rx_req_d;  // [R16]
            o_rx_error_irq <= err_req_d; // [R16]
        end
    end

    always_comb begin
        ev         = '0;
        ev[EV_TX]  = tx_req_d && !o_tx_empty_irq;
        ev[EV_RX]  = rx_req_d && !o_rx_full_irq;
        ev[EV_ERR] = err_req_d && !o_rx_error_irq;
    end

    irq_status #(
        .W (EV_W)
    ) u_irq (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_event     (ev),
        .i_wr_status (i_wr_stb && (i_addr == OFS_IRQ_STAT)),
        .i_wr_mask   (i_wr_stb && (i_addr == OFS_IRQ_MASK)),
        .i_wdata     (i_wdata[EV_W-1:0]),
        .o_status    (irq_stat),
        .o_mask      (irq_mask),
        .o_irq       (o_irq)
    );

    baud_source_sel u_baud (
        .i_clk      (i_clk),
        .i_rst      (clr_all),
        .i_sel      (clk_sel_e'(mode_q[MODE_CKS_HI:MODE_CKS_LO])), // [R1]
        .i_sub_tick (i_sub_tick),
        .i_sub_mode (i_sub_mode), // [R2]
        .o_tick     (o_baud_tick)
    );

    // Read path
    always_comb begin
        status_rd           = '0;
        status_rd[STS_TX_BUFFER_EMPTY] = flags_q.tx_buffer_empty;
        status_rd[STS_RX_BUFFER_FULL] = flags_q.rx_buffer_full;
        status_rd[STS_OER]  = flags_q.overrun_error_flag;
        status_rd[STS_FER]  = flags_q.framing_error_flag;
        status_rd[STS_PER]  = flags_q.parity_error_flag;
        status_rd[STS_TEND] = flags_q.tx_buffer_empty && i_tsr_idle;
    end

    always_comb begin
        rdata_d = '0;
        if (i_rd_stb) begin
            case (i_addr)
                OFS_MODE:     rdata_d = mode_q;
                OFS_BITRATE:  rdata_d = bitrate_q;
                OFS_CONTROL:  rdata_d = ctrl_q;
                OFS_TXDATA:   rdata_d = txd_q;
                OFS_STATUS:   rdata_d = status_rd;
                OFS_RXDATA:   rdata_d = rxd_q;
                OFS_IRQ_STAT: rdata_d = {{(DATA_W-EV_W){1'b0}}, irq_stat};
                OFS_IRQ_MASK: rdata_d = {{(DATA_W-EV_W){1'b0}}, irq_mask};
                default:      rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= rdata_d;
        end
    end

    assign o_mode      = mode_q;
    assign o_bit_rate  = bitrate_q;
    assign o_tx_enable = ctrl_q[CTL_TX_EN];
    assign o_rx_enable = ctrl_q[CTL_RX_EN]; // [R11]

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_ctrl_standby_clear: assert property (i_standby |=> ctrl_q == CONTROL_RESET) // [R3]
        else $error("control register not cleared by standby");
    chk_tx_irq_gate: assert property (!ctrl_q[CTL_TX_IRQ_EN] |=> !o_tx_empty_irq) // [R4]
        else $error("transmit request raised while disabled");
    chk_tx_irq_drop: assert property (
        $fell(flags_q.tx_buffer_empty) && !i_standby |=> !o_tx_empty_irq) // [R5]
        else $error("transmit request not withdrawn");
    chk_rx_irq_gate: assert property (
        !ctrl_q[CTL_RX_IRQ_EN] |=> !o_rx_full_irq && !o_rx_error_irq) // [R6]
        else $error("receive request raised while disabled");
    chk_rx_irq_drop: assert property ($fell(flags_q.rx_buffer_full) |=> !o_rx_full_irq) // [R7]
        else $error("receive request not withdrawn");
    chk_tx_buffer_empty_held: assert property (!ctrl_q[CTL_TX_EN] && !i_standby |=> flags_q.tx_buffer_empty) // [R8]
        else $error("empty flag not held while transmit disabled");
    chk_tdr_write: assert property (
        wr_txd && ctrl_q[CTL_TX_EN] && !tx_load_d && !i_standby |=> !flags_q.tx_buffer_empty
        ##[1:2] (o_tx_load || !i_tsr_idle || !ctrl_q[CTL_TX_EN] || !flags_q.tx_buffer_empty)) // [R9]
        else $error("data write did not clear the empty flag");
    chk_re_keeps_flags: assert property (
        $fell(ctrl_q[CTL_RX_EN]) && !$past(i_standby) |-> flags_q.rx_buffer_full
        == $past(flags_q.rx_buffer_full) || $past(rd_rxd || wr_sts || rx_ev)) // [R13]
        else $error("receive flags moved when reception was disabled");
    chk_rx_buffer_full_set: assert property (rx_ok && !i_standby |=> flags_q.rx_buffer_full ##1 1) // [R15]
        else $error("full flag not set by received byte");
    chk_irq_follow: assert property (
        ##1 o_rx_error_irq == $past(err_req_d) || $past(i_standby)) // [R16]
        else $error("error request does not follow flags and enable");

    cov_tx_load:  cover property (wr_txd ##[1:4] o_tx_load);
    cov_overrun:  cover property (rx_ev && flags_q.rx_buffer_full);
    cov_irq_out:  cover property ($rose(o_irq));

endmodule : serial_port_ctrl

// [verilog/sport_pkg.sv]
// Shared constants and types for the serial port control block.
// Assumes a single 50 MHz system clock and an 8-bit register port.
package sport_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int EV_W   = 3;

    localparam logic [ADDR_W-1:0] OFS_MODE     = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_BITRATE  = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_CONTROL  = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_TXDATA   = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_RXDATA   = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 3'h6;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h7;

    // Control register fields
    localparam int CTL_TX_IRQ_EN = 7;
    localparam int CTL_RX_IRQ_EN = 6;
    localparam int CTL_TX_EN     = 5;
    localparam int CTL_RX_EN     = 4;
    // Status register fields
    localparam int STS_TX_BUFFER_EMPTY = 7;
    localparam int STS_RX_BUFFER_FULL = 6;
    localparam int STS_OER  = 5;
    localparam int STS_FER  = 4;
    localparam int STS_PER  = 3;
    localparam int STS_TEND = 2;
    // Mode register clock-select field
    localparam int MODE_CKS_LO = 0;
    localparam int MODE_CKS_HI = 1;

    localparam logic [DATA_W-1:0] MODE_RESET    = 8'h00;
    localparam logic [DATA_W-1:0] BITRATE_RESET = 8'hff;
    localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RESET    = 8'h00;

    // Event bits of the interrupt status register
    localparam int EV_TX  = 0;
    localparam int EV_RX  = 1;
    localparam int EV_ERR = 2;

    localparam int          PRESCALE_W = 6;
    localparam logic [3:0]  DIV16_LAST = 4'hf;
    localparam logic [5:0]  DIV64_LAST = 6'h3f;

    typedef enum logic [1:0] {
        CKS_SYS,
        CKS_SUB,
        CKS_DIV16,
        CKS_DIV64
    } clk_sel_e;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              framing_err;
        logic              parity_err;
    } rx_word_s;

    typedef struct packed {
        logic tx_buffer_empty;
        logic rx_buffer_full;
        logic overrun_error_flag;
        logic framing_error_flag;
        logic parity_error_flag;
    } flags_s;

endpackage : sport_pkg

// [verilog/baud_source_sel.sv]
// Baud generator source selection: system clock, subclock, /16 or /64.
// Assumes i_sub_tick is a one-cycle pulse per subclock period.
`timescale 1ns/1ps
module baud_source_sel
    import sport_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_rst,
    input  wire clk_sel_e i_sel,
    input  wire logic     i_sub_tick,
    input  wire logic     i_sub_mode,
    output logic          o_tick
);

    logic [PRESCALE_W-1:0] cnt_q;
    logic                  sub_half_q;
    logic                  tick_d;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sub_half_q <= 1'b0;
        end else if (i_sub_tick) begin
            sub_half_q <= ~sub_half_q;
        end
    end

    always_comb begin
        case (i_sel)
            CKS_SYS:   tick_d = 1'b1;                                    // [R1]
            CKS_SUB:   tick_d = i_sub_tick & (i_sub_mode | sub_half_q);  // [R2]
            CKS_DIV16: tick_d = (cnt_q[3:0] == DIV16_LAST);             // [R1]
            CKS_DIV64: tick_d = (cnt_q == DIV64_LAST);                  // [R1]
            default:   tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= tick_d;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_sys_every_cycle: assert property (i_sel == CKS_SYS |=> o_tick) // [R1]
        else $error("system clock source did not tick");
    chk_div64_spacing: assert property (
        (i_sel == CKS_DIV64) && $stable(i_sel) && o_tick |-> $past(cnt_q) == DIV64_LAST) // [R1]
        else $error("divide by 64 tick out of place");
    chk_sub_undivided: assert property (
        (i_sel == CKS_SUB) && i_sub_mode && i_sub_tick |=> o_tick) // [R2]
        else $error("undivided subclock tick lost");

endmodule : baud_source_sel

// [verilog/irq_status.sv]
// Sticky event status with write-one-to-clear, mask and one level output.
// Assumes events are one-cycle pulses; a set wins over a clear.
`timescale 1ns/1ps
module irq_status #(
    parameter int W = 3
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_event,
    input  wire logic         i_wr_status,
    input  wire logic         i_wr_mask,
    input  wire logic [W-1:0] i_wdata,
    output logic      [W-1:0] o_status,
    output logic      [W-1:0] o_mask,
    output logic              o_irq
);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_status <= '0;
        end else begin
            o_status <= i_event | (o_status & ~(i_wr_status ? i_wdata : '0));
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_mask <= '0;
        end else if (i_wr_mask) begin
            o_mask <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(o_status & o_mask);
        end
    end

endmodule : irq_status

// [verification/serial_far_end.sv]
// Far-side model of the serial port: transmit shifter and remote sender.
// Assumes loads are one-cycle pulses and receive frames are ordered by the bench.
`timescale 1ns/1ps
module serial_far_end
    import sport_pkg::*;
#(
    parameter int BUSY = 12
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_tx_load,
    input  wire logic [DATA_W-1:0] i_tx_data,
    input  wire logic              i_send,
    input  wire rx_word_s          i_word,
    output logic                   o_tsr_idle,
    output logic                   o_rx_done,
    output rx_word_s               o_rx_word,
    output logic      [DATA_W-1:0] o_last_tx,
    output logic      [7:0]        o_n_tx
);
    logic [7:0] busy_q;
    rx_word_s   held_q;

    // Shifter is busy for BUSY cycles after each byte it takes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_q    <= 8'h00;
            o_n_tx    <= 8'h00;
            o_last_tx <= 8'h00;
        end else if (i_tx_load) begin
            busy_q    <= 8'(BUSY);
            o_n_tx    <= o_n_tx + 8'h01;
            o_last_tx <= i_tx_data;
        end else if (busy_q != 8'h00) begin
            busy_q <= busy_q - 8'h01;
        end
    end

    // A received frame ends one cycle after the bench asks for it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rx_done <= 1'b0;
            held_q    <= '0;
        end else begin
            o_rx_done <= i_send;
            if (i_send) begin
                held_q <= i_word;
            end
        end
    end

    assign o_tsr_idle = (busy_q == 8'h00);
    // Word is only meaningful with the done pulse; otherwise show garbage
    assign o_rx_word  = o_rx_done ? held_q : ~held_q;
endmodule : serial_far_end

// [verification/serial_port_clock_and_control_tb_top.sv]
// Self-checking bench of the serial port control block.
// Assumes the far-side model drives shifter idle and receive frames.
`timescale 1ns/1ps
module serial_port_clock_and_control_tb_top;
    import sport_pkg::*;
    typedef struct packed {
        logic       wr;
        logic [2:0] a;
        logic [7:0] d;
    } row_s;
    typedef struct packed {
        logic [1:0] sel;
        logic       sm;
        logic [7:0] n;
    } baud_s;

    logic        clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
    logic        standby = 1'b0, sub_tick = 1'b0, sub_mode = 1'b0, send = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00, d, rdata, mode, bit_rate, tx_data, last_tx, n_tx, cnt;
    logic [1:0]  sc = 2'h0;
    rx_word_s    word = '0, rx_word;
    logic        tsr_idle, rx_done, tx_en, rx_en, tx_load, baud_tick, tx_empty_irq, rx_full_irq, rx_error_irq, irq, a;
    int          n_fail = 0, compares = 0;
    row_s        rows[14] = '{'{1'b0, 3'h0, 8'h00}, '{1'b0, 3'h1, 8'hff},
        '{1'b0, 3'h2, 8'h00}, '{1'b0, 3'h3, 8'h00}, '{1'b0, 3'h4, 8'h84},
        '{1'b0, 3'h5, 8'h00},
        '{1'b0, 3'h6, 8'h00}, '{1'b0, 3'h7, 8'h00}, '{1'b1, 3'h1, 8'h5a},
        '{1'b0, 3'h1, 8'h5a}, '{1'b1, 3'h2, 8'hc0}, '{1'b0, 3'h2, 8'hc0},
        '{1'b1, 3'h2, 8'h00}, '{1'b0, 3'h2, 8'h00}};
    baud_s       bauds[5] = '{'{2'h0, 1'b0, 8'h80}, '{2'h1, 1'b0, 8'h10},
        '{2'h1, 1'b1, 8'h20}, '{2'h2, 1'b0, 8'h08}, '{2'h3, 1'b0, 8'h02}};

    always #10 clk = ~clk;
    always @(posedge clk) begin
        sc       <= sc + 2'h1;
        sub_tick <= (sc == 2'h3);
    end

    serial_port_ctrl serial_port_ctrl_i (.i_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .i_standby(standby),
        .i_sub_tick(sub_tick), .i_sub_mode(sub_mode), .i_tsr_idle(tsr_idle),
        .i_rx_done(rx_done), .i_rx_word(rx_word), .o_rdata(rdata), .o_mode(mode),
        .o_bit_rate(bit_rate), .o_tx_enable(tx_en), .o_rx_enable(rx_en),
        .o_tx_load(tx_load), .o_tx_data(tx_data), .o_baud_tick(baud_tick),
        .o_tx_empty_irq(tx_empty_irq), .o_rx_full_irq(rx_full_irq), .o_rx_error_irq(rx_error_irq), .o_irq(irq));
    serial_far_end serial_far_end_i (.i_clk(clk), .i_rst(rst), .i_tx_load(tx_load),
        .i_tx_data(tx_data), .i_send(send), .i_word(word), .o_tsr_idle(tsr_idle),
        .o_rx_done(rx_done), .o_rx_word(rx_word), .o_last_tx(last_tx), .o_n_tx(n_tx));

    task automatic final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic wr(input logic [2:0] a_in, input logic [7:0] d_in);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr   <= a_in;
        wdata  <= d_in;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a_in);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr   <= a_in;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd

    task automatic frame(input logic [7:0] v, input logic fe);
        @(posedge clk);
        send <= 1'b1;
        word <= '{v, fe, fe};
        @(posedge clk);
        send <= 1'b0;
        repeat (4) @(negedge clk);
    endtask : frame

    task automatic wait_loads(input logic [7:0] n);
        for (int i = 0; i < 200 && n_tx !== n; i++) begin
            @(negedge clk);
        end
        if (n_tx !== n) begin
            n_fail++;
            $display("mismatch shifter loads expected %h seen %h", n, n_tx);
            final_report();
        end
    endtask : wait_loads

    task automatic done_test(input string name);
        $display("test %s done", name);
    endtask : done_test

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[k]) begin
            if (rows[k].wr) begin
                wr(rows[k].a, rows[k].d);
            end else begin
                rd(rows[k].a);
                chk8("register read", rows[k].d, d);
            end
        end
        chk8("bit rate port", 8'h5a, bit_rate);
        done_test("registers");
        foreach (bauds[k]) begin
            sub_mode <= bauds[k].sm;
            wr(OFS_MODE, {6'h00, bauds[k].sel});
            repeat (6) @(negedge clk);
            cnt = 8'h00;
            repeat (128) begin
                @(negedge clk);
                cnt = cnt + {7'h00, baud_tick === 1'b1};
            end
            chk8("baud ticks", bauds[k].n, cnt);
            chk8("mode port", {6'h00, bauds[k].sel}, mode);
        end
        done_test("baud source");
        wr(OFS_MODE, 8'h00);
        wr(OFS_TXDATA, 8'h11);
        rd(OFS_STATUS);
        chk1("empty while tx off", 1'b1, d[STS_TX_BUFFER_EMPTY]);
        chk8("loads while tx off", 8'h00, n_tx);
        wr(OFS_CONTROL, 8'ha0);
        wr(OFS_TXDATA, 8'ha5);
        wait_loads(8'h01);
        chk1("tx enable port", 1'b1, tx_en);
        chk8("first byte", 8'ha5, last_tx);
        wr(OFS_TXDATA, 8'h3c);
        rd(OFS_STATUS);
        chk1("empty after write", 1'b0, d[STS_TX_BUFFER_EMPTY]);
        chk1("tx irq while full", 1'b0, tx_empty_irq);
        wait_loads(8'h02);
        chk8("second byte", 8'h3c, tx_data);
        repeat (3) @(negedge clk);
        chk1("tx irq when empty", 1'b1, tx_empty_irq);
        wr(OFS_CONTROL, 8'h20);
        repeat (2) @(negedge clk);
        chk1("tx irq enable off", 1'b0, tx_empty_irq);
        done_test("transmit");
        wr(OFS_CONTROL, 8'h50);
        frame(8'h3c, 1'b0);
        chk1("rx enable port", 1'b1, rx_en);
        chk1("rx irq", 1'b1, rx_full_irq);
        rd(OFS_RXDATA);
        chk8("rx data", 8'h3c, d);
        rd(OFS_STATUS);
        chk8("status after rx read", 8'h84, d);
        chk1("rx irq after read", 1'b0, rx_full_irq);
        frame(8'h11, 1'b0);
        frame(8'h22, 1'b0);
        chk1("error irq on overrun", 1'b1, rx_error_irq);
        wr(OFS_CONTROL, 8'h40);
        frame(8'h33, 1'b0);
        rd(OFS_STATUS);
        chk8("flags kept with rx off", 8'he4, d);
        wr(OFS_CONTROL, 8'h00);
        repeat (2) @(negedge clk);
        chk1("rx irq enable off", 1'b0, rx_full_irq);
        chk1("error irq enable off", 1'b0, rx_error_irq);
        rd(OFS_RXDATA);
        chk8("first frame kept", 8'h11, d);
        wr(OFS_CONTROL, 8'h50);
        frame(8'h44, 1'b1);
        rd(OFS_STATUS);
        chk8("framing error", 8'hbc, d);
        wr(OFS_STATUS, 8'h00);
        repeat (2) @(negedge clk);
        rd(OFS_STATUS);
        chk8("flags cleared", 8'h84, d);
        chk1("error irq after clear", 1'b0, rx_error_irq);
        done_test("receive");
        wr(OFS_IRQ_STAT, 8'h07);
        rd(OFS_IRQ_STAT);
        chk8("irq status cleared", 8'h00, d);
        frame(8'h55, 1'b0);
        rd(OFS_IRQ_STAT);
        chk8("rx event sticky", 8'h02, d);
        wr(OFS_IRQ_MASK, 8'h00);
        repeat (2) @(negedge clk);
        a = irq;
        wr(OFS_IRQ_MASK, 8'h07);
        repeat (2) @(negedge clk);
        chk1("mask changes irq", 1'b1, a ^ irq);
        wr(OFS_IRQ_STAT, 8'h02);
        repeat (2) @(negedge clk);
        chk1("irq after clear", 1'b0, irq);
        done_test("interrupt");
        @(posedge clk);
        standby <= 1'b1;
        repeat (2) @(posedge clk);
        standby <= 1'b0;
        rd(OFS_CONTROL);
        chk8("control after standby", 8'h00, d);
        rd(OFS_STATUS);
        chk8("status after standby", 8'h84, d);
        chk8("bit rate after standby", 8'hff, bit_rate);
        chk1("rx irq after standby", 1'b0, rx_full_irq);
        done_test("standby");
        final_report();
    end
endmodule : serial_port_clock_and_control_tb_top
